//--- hdl/fetch_cfg.svh
// Purpose: constants for the fetch and program counter block
// Assumes: 10 MHz system clock, classic Wishbone register port
// Notes: register word offsets are byte addresses
`ifndef FETCH_CFG_SVH
`define FETCH_CFG_SVH
`define PC_LOW_WIDTH 8
`define PC_PAGE_WIDTH 13
`define PC_RESET_ADDR 16'h0000
`define PHASE_RESET_STROBE 4'h8
`define REG_PC_LOW 4'h0
`define REG_BANK 4'h4
`define REG_CTRL 4'h8
`define REG_STATUS 4'hC
`define CTRL_BRANCH 0
`define CTRL_SKIP 1
`define STAT_DUMMY 0
`define STAT_PHASE_LO 1
`define STAT_PHASE_HI 2
`endif

//--- hdl/fetch_pkg.sv
// Purpose: types for the fetch and program counter block
// Assumes: nothing beyond the cfg header
// Notes: all state of the block sits in one packed struct
package fetch_pkg;
   typedef enum logic [1:0] {
      PH_FIRST = 2'b00,
      PH_SECOND = 2'b01,
      PH_THIRD = 2'b10,
      PH_FOURTH = 2'b11
   } phase_type;

   typedef struct packed {
      phase_type phase;
      logic [15:0] pc;
      logic [2:0] bank;
      logic dummy;
      logic branch_pend;
      logic [15:0] branch_addr;
      logic skip_pend;
      logic low_wr_pend;
      logic [7:0] low_wr_val;
      logic [3:0] phase_clocks;
      logic ack;
      logic [31:0] rdata;
   } state_type;
endpackage

//--- hdl/fetch_pc.sv
// Purpose: instruction cycle phasing and program counter control
// Assumes: one 10 MHz clock, synchronous reset, classic Wishbone slave
// Notes: branch and skip requests come from the decoder on the same clock
`timescale 1ns/1ns
`include "fetch_cfg.svh"

module fetch_pc #(
   parameter int BANK_BITS = 3
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic branch_req_i,
   input wire logic [15:0] branch_addr_i,
   input wire logic skip_req_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic [15:0] fetch_addr_o,
   output logic [2:0] program_bank_select_bits_o,
   output logic [3:0] instruction_phase_clocks_o,
   output logic dummy_cycle_o
);
   // bank bits sit above a 13-bit page counter; more would overflow 16 bits
   initial begin
      if (BANK_BITS < 0 || BANK_BITS > 3) begin
         $error("BANK_BITS must be 0 to 3");
      end
   end

   localparam logic [15:0] PC_MASK = 16'((32'h1 << (`PC_PAGE_WIDTH + BANK_BITS)) - 1);
   localparam logic [2:0] BANK_MASK = 3'((32'h1 << BANK_BITS) - 1);

   fetch_pkg::state_type s_q;
   fetch_pkg::state_type s_d;

   logic bus_req;
   logic [3:0] reg_sel;
   assign bus_req = wb_cyc_i && wb_stb_i && !s_q.ack;
   assign reg_sel = wb_adr_i[3:0];

   // request decodes for the checks; low_wr_hit also feeds the next-state logic
   logic bus_take;
   logic low_wr_hit;
   assign bus_take = ce_i && bus_req;
   assign low_wr_hit = bus_req && wb_we_i && wb_sel_i[0] && reg_sel == `REG_PC_LOW;

   // one process builds the whole next state
   always_comb begin
      logic [15:0] seq_pc;
      seq_pc = 16'h0000;
      s_d = s_q;
      s_d.ack = 1'b0;
      s_d.phase = fetch_pkg::phase_type'(2'(s_q.phase + 2'h1));
      s_d.phase_clocks = 4'h1 << s_d.phase;
      // requests latch any time; the next phase one acts on one: branch, else low write, else skip
      if (branch_req_i) begin
         s_d.branch_pend = 1'b1;
         s_d.branch_addr = branch_addr_i;
      end
      if (skip_req_i) begin
         s_d.skip_pend = 1'b1;
      end
      // Wishbone slave: one wait state, ack drops the cycle after it rose
      if (bus_req) begin
         s_d.ack = 1'b1;
         s_d.rdata = 32'h0000_0000;
         case (reg_sel)
            `REG_PC_LOW: begin
               s_d.rdata[7:0] = s_q.pc[7:0];
               if (wb_we_i && wb_sel_i[0]) begin
                  s_d.low_wr_pend = 1'b1;
                  s_d.low_wr_val = wb_dat_i[7:0];
               end
            end
            `REG_BANK: begin
               s_d.rdata[2:0] = s_q.bank;
            end
            `REG_STATUS: begin
               s_d.rdata[`STAT_DUMMY] = s_q.dummy;
               s_d.rdata[`STAT_PHASE_HI:`STAT_PHASE_LO] = s_q.phase;
            end
            default: begin
               s_d.rdata = 32'h0000_0000;
            end
         endcase
      end
      if (s_q.phase == fetch_pkg::PH_FOURTH) begin
         s_d.dummy = 1'b0;
         seq_pc = 16'(s_q.pc + 16'h0001) & PC_MASK;
         s_d.pc = seq_pc;
         if (s_q.branch_pend) begin
            s_d.pc = s_q.branch_addr & PC_MASK;
            s_d.dummy = 1'b1;
            s_d.branch_pend = branch_req_i; // a request in this edge survives
         end else if (s_q.low_wr_pend) begin
            s_d.pc = {s_q.pc[15:`PC_LOW_WIDTH], s_q.low_wr_val};
            s_d.dummy = 1'b1;
            s_d.low_wr_pend = low_wr_hit; // a write in this edge survives
         end else if (s_q.skip_pend) begin
            s_d.dummy = 1'b1;
            s_d.skip_pend = skip_req_i; // a skip in this edge survives
         end
         s_d.bank = 3'(s_d.pc >> `PC_PAGE_WIDTH) & BANK_MASK;
      end
   end

   // single state register; clock enable freezes everything except reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
         s_q.pc <= `PC_RESET_ADDR;
         s_q.phase <= fetch_pkg::PH_FOURTH;
         s_q.phase_clocks <= `PHASE_RESET_STROBE;
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state register
   assign wb_ack_o = s_q.ack;
   assign wb_dat_o = s_q.rdata;
   assign fetch_addr_o = s_q.pc;
   assign program_bank_select_bits_o = s_q.bank;
   assign instruction_phase_clocks_o = s_q.phase_clocks;
   assign dummy_cycle_o = s_q.dummy;

   a_phase_onehot: assert property (@(posedge clk_i) disable iff (rst_i)
      $onehot(instruction_phase_clocks_o))
      else $error("phase strobes not one-hot");

   a_phase_order: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && instruction_phase_clocks_o == 4'h1
      |=> instruction_phase_clocks_o == 4'h2)
      else $error("phase order broken");

   a_phase_second: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && instruction_phase_clocks_o == 4'h2
      |=> instruction_phase_clocks_o == 4'h4)
      else $error("phase two not followed by three");

   a_phase_third: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && instruction_phase_clocks_o == 4'h4
      |=> instruction_phase_clocks_o == 4'h8)
      else $error("phase three not followed by four");

   a_phase_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && instruction_phase_clocks_o == 4'h8
      |=> instruction_phase_clocks_o == 4'h1)
      else $error("phase four not followed by one");

   a_exec_phases: assert property (@(posedge clk_i) disable iff (rst_i)
      s_q.phase != fetch_pkg::PH_FIRST |-> !instruction_phase_clocks_o[0])
      else $error("fetch strobe in an execute phase");

   a_pc_stable: assert property (@(posedge clk_i) disable iff (rst_i)
      s_q.phase != fetch_pkg::PH_FOURTH
      |=> $stable(fetch_addr_o))
      else $error("counter moved outside phase one");

   a_bank_stable: assert property (@(posedge clk_i) disable iff (rst_i)
      s_q.phase != fetch_pkg::PH_FOURTH
      |=> $stable(program_bank_select_bits_o))
      else $error("bank moved outside phase one");

   a_freeze_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      !ce_i
      |=> $stable(fetch_addr_o) && $stable(instruction_phase_clocks_o) && $stable(wb_ack_o))
      else $error("state moved while frozen");

   a_seq_incr: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && s_q.phase == fetch_pkg::PH_FOURTH && !s_q.branch_pend && !s_q.low_wr_pend
      |=> fetch_addr_o == 16'(($past(fetch_addr_o) + 16'h0001) & PC_MASK))
      else $error("sequential increment wrong");

   a_plain_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && s_q.phase == fetch_pkg::PH_FOURTH && !s_q.branch_pend && !s_q.low_wr_pend &&
      !s_q.skip_pend |=> !dummy_cycle_o)
      else $error("dummy cycle without cause");

   a_branch_load: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && s_q.phase == fetch_pkg::PH_FOURTH && s_q.branch_pend
      |=> fetch_addr_o == ($past(s_q.branch_addr) & PC_MASK) && dummy_cycle_o)
      else $error("branch target not loaded");

   a_branch_latch: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && branch_req_i
      |=> s_q.branch_pend && s_q.branch_addr == $past(branch_addr_i))
      else $error("branch request lost");

   a_page_jump: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && s_q.phase == fetch_pkg::PH_FOURTH && !s_q.branch_pend && s_q.low_wr_pend
      |=> fetch_addr_o[15:8] == $past(fetch_addr_o[15:8]) && dummy_cycle_o)
      else $error("low byte write left the page");

   // page jump lands on written byte
   a_page_low: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && s_q.phase == fetch_pkg::PH_FOURTH && !s_q.branch_pend && s_q.low_wr_pend
      |=> fetch_addr_o[7:0] == $past(s_q.low_wr_val))
      else $error("low byte write landed wrong");

   a_low_latch: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && low_wr_hit
      |=> s_q.low_wr_pend && s_q.low_wr_val == $past(wb_dat_i[7:0]))
      else $error("low byte write lost");

   a_dummy_source: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(dummy_cycle_o)
      |-> $past(s_q.phase) == fetch_pkg::PH_FOURTH)
      else $error("dummy rose mid cycle");

   a_skip_dummy: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && s_q.phase == fetch_pkg::PH_FOURTH && s_q.skip_pend
      |=> dummy_cycle_o)
      else $error("skip gave no dummy cycle");

   a_skip_latch: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && skip_req_i
      |=> s_q.skip_pend)
      else $error("skip request lost");

   a_dummy_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      s_q.phase != fetch_pkg::PH_FOURTH
      |=> $stable(dummy_cycle_o))
      else $error("dummy changed mid cycle");

   a_reset_zero: assert property (@(posedge clk_i)
      rst_i
      |=> fetch_addr_o == `PC_RESET_ADDR)
      else $error("counter not zero after reset");

   a_reset_phase: assert property (@(posedge clk_i)
      rst_i
      |=> instruction_phase_clocks_o == `PHASE_RESET_STROBE && !dummy_cycle_o && !wb_ack_o)
      else $error("reset state wrong");

   a_first_fetch: assert property (@(posedge clk_i)
      rst_i ##1 (!rst_i && ce_i)
      |=> fetch_addr_o == 16'h0001 && instruction_phase_clocks_o == 4'h1)
      else $error("first cycle after reset wrong");

   a_bank_bits: assert property (@(posedge clk_i) disable iff (rst_i)
      program_bank_select_bits_o == (3'(fetch_addr_o >> `PC_PAGE_WIDTH) & BANK_MASK))
      else $error("bank bits disagree with counter");

   a_addr_mask: assert property (@(posedge clk_i) disable iff (rst_i)
      (fetch_addr_o & ~PC_MASK) == 16'h0000)
      else $error("address beyond memory size");

   a_bank_mask: assert property (@(posedge clk_i) disable iff (rst_i)
      (program_bank_select_bits_o & ~BANK_MASK) == 3'h0)
      else $error("bank bits beyond bank count");

   a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o && ce_i
      |=> !wb_ack_o)
      else $error("ack held two cycles");

   a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
      bus_take
      |=> wb_ack_o)
      else $error("request not answered");

   a_ack_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && !(wb_cyc_i && wb_stb_i)
      |=> !wb_ack_o)
      else $error("ack without request");

   a_low_read: assert property (@(posedge clk_i) disable iff (rst_i)
      bus_take && reg_sel == `REG_PC_LOW
      |=> wb_dat_o == {24'h00_0000, $past(fetch_addr_o[7:0])})
      else $error("low byte read wrong");

   a_bank_read: assert property (@(posedge clk_i) disable iff (rst_i)
      bus_take && reg_sel == `REG_BANK
      |=> wb_dat_o == {29'h0000_0000, $past(program_bank_select_bits_o)})
      else $error("bank read wrong");

   a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      bus_take && reg_sel == `REG_CTRL
      |=> wb_dat_o == 32'h0000_0000)
      else $error("reserved read not zero");

   a_status_read: assert property (@(posedge clk_i) disable iff (rst_i)
      bus_take && reg_sel == `REG_STATUS
      |=> wb_dat_o == {29'h0000_0000, $past(s_q.phase), $past(dummy_cycle_o)})
      else $error("status read wrong");
endmodule

//--- test/prog_mem_model.sv
// Purpose: program memory on the far side of the fetch block
// Assumes: one word addressed per instruction cycle, at phase one
// Notes: outside phase one the word toggles so a stale word never looks valid
`timescale 1ns/1ns
module prog_mem_model (
   input wire logic clk_i,
   input wire logic [15:0] addr_i,
   input wire logic [3:0] phase_i,
   output logic [15:0] word_o
);
   // content is a fixed function of the address, so no storage is needed
   always_ff @(posedge clk_i) begin
      if (phase_i == 4'h1) begin
         word_o <= addr_i ^ 16'hA5C3;
      end else begin
         word_o <= ~word_o;
      end
   end
endmodule

//--- test/fetch_pc_bench.sv
// Purpose: self-checking bench for the fetch and program counter block
// Assumes: inputs driven on the rising edge, outputs sampled on the falling edge except bus ack and read data
// Notes: decoder requests and low byte writes land at the next phase one unless a higher-priority one is pending
`timescale 1ns/1ns
module fetch_pc_bench;
   logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, br = 1'b0, sk = 1'b0;
   logic we = 1'b0, cyc = 1'b0, stb = 1'b0, ack, dummy;
   logic [15:0] br_addr = 16'h0000, pc, word;
   logic [31:0] adr = 32'h0, wdat = 32'h0, rdat, rd;
   logic [3:0] ph, ph_hold;
   logic [15:0] pc_hold;
   logic [2:0] bank;
   int n_fail = 0, checks = 0, cyc_n = 0;
   // phase strobe and counter after each edge from reset
   logic [19:0] rows [10] = '{20'h80000, 20'h10001, 20'h20001, 20'h40001, 20'h80001,
      20'h10002, 20'h20002, 20'h40002, 20'h80002, 20'h10003};
   fetch_pc dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .branch_req_i(br),
      .branch_addr_i(br_addr), .skip_req_i(sk), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_sel_i(4'h1), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
      .wb_ack_o(ack), .fetch_addr_o(pc), .program_bank_select_bits_o(bank),
      .instruction_phase_clocks_o(ph), .dummy_cycle_o(dummy));
   prog_mem_model mem_u (.clk_i(clk_i), .addr_i(pc), .phase_i(ph), .word_o(word));
   // 100 ns clock
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   // classic cycle: hold everything until ack is seen at a rising edge
   task automatic wb(input logic [31:0] a, input logic w, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      adr <= a;
      we <= w;
      wdat <= d;
      // ack seen at a rising edge ends this wait, or else the hang guard
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wait_p1();
      int n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (ph !== 4'h1 && n < 8);
   endtask
   // one-cycle decoder request raised in phase two
   task automatic pulse(input logic b, input logic s, input logic [15:0] a);
      @(posedge clk_i);
      br <= b;
      sk <= s;
      br_addr <= a;
      @(posedge clk_i);
      br <= 1'b0;
      sk <= 1'b0;
      wait_p1();
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // hang guard, well above the fewer than 100 cycles the tests need
   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n == 3000) begin
         n_fail++;
         conclude();
      end
   end
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (rows[i]) begin
         @(negedge clk_i);
         chk("phase", {28'h0, rows[i][19:16]}, {28'h0, ph});
         chk("pc", {16'h0, rows[i][15:0]}, {16'h0, pc});
      end
      $display("sequence test done");
      wait_p1();
      pulse(1'b1, 1'b0, 16'hA234);
      chk("branch", 32'h1A234, {15'h0, dummy, pc});
      chk("bank", 32'h5, {29'h0, bank});
      wait_p1();
      chk("after branch", 32'hA235, {15'h0, dummy, pc});
      pulse(1'b0, 1'b1, 16'h0000);
      chk("skip", 32'h1A236, {15'h0, dummy, pc});
      wb(32'h0, 1'b1, 32'h5A);
      wait_p1();
      chk("page jump", 32'h1A25A, {15'h0, dummy, pc});
      wb(32'h0, 1'b0, 32'h0);
      chk("low byte", 32'h5A, rd);
      wb(32'h4, 1'b1, 32'hFF);
      wb(32'h4, 1'b0, 32'h0);
      chk("bank read", 32'h5, rd);
      wb(32'h8, 1'b0, 32'h0);
      chk("reserved", 32'h0, rd);
      wb(32'hC, 1'b0, 32'h0);
      // read in phase two (code 1), dummy bit clear
      chk("status", 32'h2, rd);
      $display("branch skip and register tests done");
      @(posedge clk_i);
      ce_i <= 1'b0;
      @(negedge clk_i);
      pc_hold = pc;
      ph_hold = ph;
      repeat (5) @(posedge clk_i);
      @(negedge clk_i);
      chk("freeze pc", {16'h0, pc_hold}, {16'h0, pc});
      chk("freeze phase", {28'h0, ph_hold}, {28'h0, ph});
      @(posedge clk_i);
      ce_i <= 1'b1;
      wait_p1();
      @(negedge clk_i);
      chk("fetch word", {16'h0, pc ^ 16'hA5C3}, {16'h0, word});
      $display("freeze and fetch tests done");
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      chk("second reset", 32'h80000, {12'h0, ph, pc});
      $display("reset test done");
      conclude();
   end
endmodule
